// ---- rtl/fsps_defines.svh ----
// Purpose: Constants of the flash self-program sequencer
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Widths, offsets, codes and timing counts
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH

// Register byte offsets
`define FSPS_OFS_CTRL 5'h00
`define FSPS_OFS_POINTER 5'h04
`define FSPS_OFS_DATA 5'h08
`define FSPS_OFS_STATUS 5'h0C
`define FSPS_OFS_RESULT 5'h10
`define FSPS_OFS_STORE 5'h14
`define FSPS_OFS_LOAD 5'h18

// Flash organisation
`define FSPS_WORD_BITS 4
`define FSPS_PAGE_BITS 7

// Control field layout and reset values
`define FSPS_CTRL_LSB 0
`define FSPS_CTRL_MSB 5
`define FSPS_CTRL_RST 6'h00
`define FSPS_BUF_ERASED 16'hFFFF

// Command patterns in the low six control bits
`define FSPS_CMD_SIG 6'h21
`define FSPS_CMD_CLR 6'h11
`define FSPS_CMD_FUSE 6'h09
`define FSPS_CMD_WRITE 6'h05
`define FSPS_CMD_ERASE 6'h03
`define FSPS_CMD_LOAD 6'h01

// Status bit positions
`define FSPS_ST_BUSY 0
`define FSPS_ST_EEBUSY 1
`define FSPS_ST_FUSE 2
`define FSPS_ST_ARMED 3

// Instruction windows in clock cycles
`define FSPS_ARM_WIN 3'h4
`define FSPS_READ_WIN 3'h3

// Erase and write time, counted in oscillator ticks
`define FSPS_OP_MIN_US 3700
`define FSPS_OP_MAX_US 4500
`define FSPS_OSC_KHZ 8000
`define FSPS_OP_TICKS (`FSPS_OP_MIN_US * `FSPS_OSC_KHZ / 1000)

// Signature table, values arbitrary
`define FSPS_SIG0 8'h5A
`define FSPS_SIG1 8'hA5
`define FSPS_SIG2 8'h3C
`define FSPS_SIG3 8'hC3

`endif

// ---- rtl/fsps_page_buffer.sv ----
// Purpose: Temporary page buffer, one flip-flop word per page word
// Assumes: Clear has priority over a write in the same cycle
// Notes: Read port is registered, one cycle latency
`timescale 1ns/10ps
`include "fsps_defines.svh"
module fsps_page_buffer #(
  parameter int WORD_BITS = `FSPS_WORD_BITS
) (
  // Clock
  input wire logic i_clk,
  // Clear and fill
  input wire logic i_clear,
  input wire logic i_wr,
  input wire logic [WORD_BITS-1:0] i_wr_idx,
  input wire logic [15:0] i_wr_data,
  // Read towards the flash array
  input wire logic [WORD_BITS-1:0] i_rd_idx,
  output logic [15:0] o_rd_data
);

  logic [15:0] word_reg [2**WORD_BITS];

  // One storage word per index
  genvar g;
  generate
    for (g = 0; g < 2**WORD_BITS; g++) begin : g_word
      always_ff @(posedge i_clk) begin
        if (i_clear) begin
          word_reg[g] <= `FSPS_BUF_ERASED;
        end else if (i_wr && i_wr_idx == WORD_BITS'(g)) begin
          word_reg[g] <= i_wr_data;
        end
      end
    end
  endgenerate

  // Registered read
  always_ff @(posedge i_clk) begin
    o_rd_data <= word_reg[i_rd_idx];
  end

endmodule : fsps_page_buffer

// ---- rtl/fsps_pkg.sv ----
// Purpose: Types of the flash self-program sequencer
// Assumes: Used by name, never imported
// Notes: Control bits travel as one packed struct
package fsps_pkg;

  // Low six bits of the control register, bit 5 first
  typedef struct packed {
    logic sig;
    logic clr;
    logic fuse;
    logic pg_write;
    logic pg_erase;
    logic arm;
  } fsps_ctrl_t;

  // Sequencer states
  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_LREAD,
    FSPS_OP
  } fsps_state_t;

endpackage : fsps_pkg

// ---- rtl/fsps_sequencer.sv ----
// Purpose: Flash self-program sequencer with Avalon-MM register slave
// Assumes: EEPROM and fuse inputs come from logic on i_clk
// Notes: i_rst is system reset; i_por_rst clears everything
//
// Functional notes
// - Store ignores pointer bit 0 and pointer bits above the page field.
// - Word field addresses the buffer; software keeps it zero for writes.
// - Page address is latched when erase or write starts.
// - Erase runs on code 000011 plus store within four cycles.
// - Load stores the data pair in the buffer word, code 000001.
// - Buffer clears after page write, on flush write and on reset; a system reset during erase or write leaves it.
// - An EEPROM write during page loading discards the buffer.
// - Write runs on code 000101 plus store within four cycles.
// - CPU stays stalled for the whole erase or write.
// - EEPROM busy blocks programming commands and fuse or lock reads.
// - A running erase or write completes across a system reset.
// - Erase and write timed by 8 MHz oscillator, 3.7 to 4.5 ms.
// - Signature command plus load within three cycles returns table byte.
// - Clear-buffer command empties the whole temporary buffer.
// - Fuse command plus load within three cycles: pointer bit 0 picks.
// - Erase and write bits clear on completion or window timeout.
// - Plain loads read flash bytes, pointer bit 0 picks the byte.
// - Arm bit opens four cycles, stays high through erase or write.
// - Any other low six-bit pattern written to control is ignored.
// - Store works only while the self-program fuse reads zero.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "fsps_defines.svh"
module fsps_sequencer #(
  parameter int WORD_BITS = `FSPS_WORD_BITS,
  parameter int PAGE_BITS = `FSPS_PAGE_BITS,
  parameter int OP_TICKS = `FSPS_OP_TICKS
) (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_rst,
  // Avalon-MM slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Neighbour status
  input wire logic i_eeprom_write_busy,
  input wire logic i_self_program_fuse,
  input wire logic [7:0] i_fuse_byte,
  input wire logic [7:0] i_lock_byte,
  // Calibrated oscillator pin
  input wire logic i_osc_8m,
  // Flash array
  output logic o_prog_start,
  output logic o_prog_erase,
  output logic [PAGE_BITS-1:0] o_prog_page,
  input wire logic [WORD_BITS-1:0] i_flash_buf_idx,
  output logic [15:0] o_buf_word,
  output logic [14:0] o_flash_raddr,
  input wire logic [15:0] i_flash_rdata,
  // CPU halt
  output logic o_cpu_stall
);

  localparam int PTR_TOP = WORD_BITS + PAGE_BITS;

  // Offset match used for every register
  function automatic logic fsps_hit(input logic [4:0] addr,
                                    input logic [4:0] ofs);
    fsps_hit = (addr[4:2] == ofs[4:2]);
  endfunction : fsps_hit

  fsps_pkg::fsps_state_t state_reg;
  fsps_pkg::fsps_state_t state_next;
  fsps_pkg::fsps_ctrl_t ctrl_reg;
  fsps_pkg::fsps_ctrl_t ctrl_next;
  logic [15:0] pointer_reg;
  logic [15:0] data_reg;
  logic [7:0] result_reg;
  logic [2:0] win_reg;
  logic [15:0] tick_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic start_reg;
  logic erase_reg;
  logic [PAGE_BITS-1:0] page_reg;
  logic [14:0] raddr_reg;
  logic byte_sel_reg;
  logic stall_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic ee_prev_reg;

  // Bus handshake decode
  wire busy = (state_reg != fsps_pkg::FSPS_IDLE);
  wire wr_acc = i_write & ~wait_reg;
  wire wr_ctrl = wr_acc & fsps_hit(i_address, `FSPS_OFS_CTRL);
  wire wr_ptr = wr_acc & fsps_hit(i_address, `FSPS_OFS_POINTER);
  wire wr_data = wr_acc & fsps_hit(i_address, `FSPS_OFS_DATA);
  wire wr_store = wr_acc & fsps_hit(i_address, `FSPS_OFS_STORE);
  wire wr_load = wr_acc & fsps_hit(i_address, `FSPS_OFS_LOAD);

  // Address fields of the pointer
  wire [WORD_BITS-1:0] word_field = pointer_reg[WORD_BITS:1];
  wire [PAGE_BITS-1:0] page_field = pointer_reg[PTR_TOP:WORD_BITS+1];
  wire z0 = pointer_reg[0];

  // Control write decode
  wire [5:0] wr_code = i_writedata[`FSPS_CTRL_MSB:`FSPS_CTRL_LSB];
  wire code_ok = (wr_code == `FSPS_CMD_SIG) | (wr_code == `FSPS_CMD_CLR)
    | (wr_code == `FSPS_CMD_FUSE) | (wr_code == `FSPS_CMD_WRITE)
    | (wr_code == `FSPS_CMD_ERASE) | (wr_code == `FSPS_CMD_LOAD);
  wire ctrl_take = wr_ctrl & i_byteenable[0] & code_ok
    & ~i_eeprom_write_busy;
  wire clear_cmd = ctrl_take & (wr_code == `FSPS_CMD_CLR);

  // Instruction windows
  wire arm_open = ctrl_reg.arm & (win_reg < `FSPS_ARM_WIN);
  wire read_open = ctrl_reg.arm & (win_reg < `FSPS_READ_WIN);
  wire timeout = ctrl_reg.arm & (win_reg == `FSPS_ARM_WIN)
    & ~busy;
  wire store_ok = wr_store & arm_open & ~busy & ~i_self_program_fuse
    & ~i_eeprom_write_busy;
  wire op_go = store_ok & (ctrl_reg.pg_erase | ctrl_reg.pg_write);
  wire buf_load = store_ok & (ctrl_reg == `FSPS_CMD_LOAD);
  wire special = ctrl_reg.sig | ctrl_reg.fuse;
  wire load_sp = wr_load & read_open & special & ~busy;
  wire load_plain = wr_load & ~special & ~busy;

  // Oscillator edge and erase or write completion
  wire osc_tick = osc_s2_reg & ~osc_s3_reg;
  wire op_done = (state_reg == fsps_pkg::FSPS_OP) & osc_tick
    & (tick_reg == 16'(OP_TICKS - 1));

  // Operations survive system reset, only power-on stops them
  wire op_run = (state_reg == fsps_pkg::FSPS_OP);
  wire soft_rst = i_por_rst | (i_rst & ~op_run);

  // Buffer clear sources
  wire ee_rise = i_eeprom_write_busy & ~ee_prev_reg;
  wire buf_clear = soft_rst | clear_cmd | ee_rise
    | (op_done & ~erase_reg);

  // Signature table lookup
  wire [7:0] sig_byte = (pointer_reg[2:1] == 2'h0) ? `FSPS_SIG0 :
    (pointer_reg[2:1] == 2'h1) ? `FSPS_SIG1 :
    (pointer_reg[2:1] == 2'h2) ? `FSPS_SIG2 : `FSPS_SIG3;
  wire [7:0] fuse_lock = z0 ? i_fuse_byte : i_lock_byte;

  // Read data selection, reserved bits zero
  wire [31:0] rd_mux =
    fsps_hit(i_address, `FSPS_OFS_CTRL) ? {26'h0, ctrl_reg} :
    fsps_hit(i_address, `FSPS_OFS_POINTER) ? {16'h0, pointer_reg} :
    fsps_hit(i_address, `FSPS_OFS_DATA) ? {16'h0, data_reg} :
    fsps_hit(i_address, `FSPS_OFS_STATUS) ?
      {28'h0, ctrl_reg.arm, ~i_self_program_fuse, i_eeprom_write_busy,
       busy} :
    fsps_hit(i_address, `FSPS_OFS_RESULT) ? {24'h0, result_reg} :
    32'h0;

  // Control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (op_done) begin
      ctrl_next = `FSPS_CTRL_RST;
    end else if (ctrl_take && !busy) begin
      ctrl_next = wr_code;
    end else if (store_ok && !op_go) begin
      ctrl_next = `FSPS_CTRL_RST;
    end else if (load_sp || timeout) begin
      ctrl_next = `FSPS_CTRL_RST;
    end
  end

  // Sequencer state next value
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsps_pkg::FSPS_IDLE: begin
        if (op_go) begin
          state_next = fsps_pkg::FSPS_OP;
        end else if (load_plain) begin
          state_next = fsps_pkg::FSPS_LREAD;
        end
      end
      fsps_pkg::FSPS_LREAD: begin
        state_next = fsps_pkg::FSPS_IDLE;
      end
      fsps_pkg::FSPS_OP: begin
        if (op_done) begin
          state_next = fsps_pkg::FSPS_IDLE;
        end
      end
      default: begin
        state_next = fsps_pkg::FSPS_IDLE;
      end
    endcase
  end

  // Bus handshake, held off while busy stalls the CPU
  always_ff @(posedge i_clk) begin
    if (i_rst || i_por_rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= ~((i_read | i_write) & wait_reg & ~busy);
      if (i_read && wait_reg && !busy) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Pointer and data pair
  always_ff @(posedge i_clk) begin
    if (i_rst || i_por_rst) begin
      pointer_reg <= 16'h0;
      data_reg <= 16'h0;
    end else begin
      if (wr_ptr && i_byteenable[0]) begin
        pointer_reg[7:0] <= i_writedata[7:0];
      end
      if (wr_ptr && i_byteenable[1]) begin
        pointer_reg[15:8] <= i_writedata[15:8];
      end
      if (wr_data && i_byteenable[0]) begin
        data_reg[7:0] <= i_writedata[7:0];
      end
      if (wr_data && i_byteenable[1]) begin
        data_reg[15:8] <= i_writedata[15:8];
      end
    end
  end

  // Control bits and arm window counter
  always_ff @(posedge i_clk) begin
    if (soft_rst) begin
      ctrl_reg <= `FSPS_CTRL_RST;
      win_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (ctrl_take && !busy) begin
        win_reg <= 3'h0;
      end else if (win_reg != `FSPS_ARM_WIN) begin
        win_reg <= win_reg + 3'h1;
      end
    end
  end

  // Erase and write sequencing, kept through system reset
  always_ff @(posedge i_clk) begin
    if (i_por_rst || (i_rst && !op_run)) begin
      state_reg <= fsps_pkg::FSPS_IDLE;
      tick_reg <= 16'h0;
      start_reg <= 1'b0;
      erase_reg <= 1'b0;
      page_reg <= '0;
      stall_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= op_go;
      if (op_go) begin
        erase_reg <= ctrl_reg.pg_erase;
        page_reg <= page_field;
        tick_reg <= 16'h0;
      end else if (osc_tick && op_run) begin
        tick_reg <= tick_reg + 16'h1;
      end
      stall_reg <= (op_go | op_run) & ~op_done;
    end
  end

  // Flash reads and load results
  always_ff @(posedge i_clk) begin
    if (i_rst || i_por_rst) begin
      result_reg <= 8'h0;
      raddr_reg <= 15'h0;
      byte_sel_reg <= 1'b0;
    end else begin
      if (load_plain) begin
        raddr_reg <= pointer_reg[15:1];
        byte_sel_reg <= z0;
      end
      if (state_reg == fsps_pkg::FSPS_LREAD) begin
        result_reg <= byte_sel_reg ? i_flash_rdata[15:8] :
          i_flash_rdata[7:0];
      end else if (load_sp && ctrl_reg.sig) begin
        result_reg <= sig_byte;
      end else if (load_sp && !i_eeprom_write_busy) begin
        result_reg <= fuse_lock;
      end
    end
  end

  // Oscillator synchroniser and EEPROM edge history
  always_ff @(posedge i_clk) begin
    if (i_por_rst) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      ee_prev_reg <= 1'b0;
    end else begin
      osc_s1_reg <= i_osc_8m;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      ee_prev_reg <= i_eeprom_write_busy;
    end
  end

  // Temporary page buffer
  fsps_page_buffer #(
    .WORD_BITS(WORD_BITS)
  ) u_buffer (
    .i_clk(i_clk),
    .i_clear(buf_clear),
    .i_wr(buf_load),
    .i_wr_idx(word_field),
    .i_wr_data(data_reg),
    .i_rd_idx(i_flash_buf_idx),
    .o_rd_data(o_buf_word)
  );

  // Output drive
  assign o_readdata = rdata_reg;
  assign o_waitrequest = wait_reg;
  assign o_prog_start = start_reg;
  assign o_prog_erase = erase_reg;
  assign o_prog_page = page_reg;
  assign o_flash_raddr = raddr_reg;
  assign o_cpu_stall = stall_reg;

endmodule : fsps_sequencer

// ---- sim/fsps_flash_model.sv ----
// Purpose: Flash array read port and calibrated oscillator
// Assumes: Word contents derive from the word address
// Notes: Oscillator runs free, one period per six clocks
`timescale 1ns/10ps
module fsps_flash_model (
  // Clock
  input wire logic i_clk,
  // Read port
  input wire logic [14:0] i_raddr,
  output logic [15:0] o_rdata,
  // Oscillator
  output logic o_osc
);
  logic [1:0] div_reg = 2'h0;
  // Predictable word per address
  assign o_rdata = {i_raddr[7:0] ^ 8'h3C, i_raddr[14:7]};
  // Oscillator divider
  initial o_osc = 1'b0;
  always @(posedge i_clk) begin
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    if (div_reg == 2'h2)
      o_osc <= ~o_osc;
  end
endmodule : fsps_flash_model

// ---- sim/fsps_sequencer_sva.sv ----
// Purpose: Port-level checks of the flash self-program sequencer
// Assumes: Bench oscillator period is six clocks
// Notes: Attached by bind at the foot of this file
`timescale 1ns/10ps
`include "fsps_defines.svh"
module fsps_sequencer_sva #(
  parameter int PAGE_BITS = 7,
  parameter int OP_TICKS = 8
) (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_rst,
  // Bus
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Status inputs
  input wire logic i_eeprom_write_busy,
  input wire logic i_self_program_fuse,
  // Flash side
  input wire logic o_prog_start,
  input wire logic o_prog_erase,
  input wire logic [PAGE_BITS-1:0] o_prog_page,
  input wire logic [15:0] o_buf_word,
  input wire logic o_cpu_stall
);
  // Allowed stall length in clocks
  localparam int OSC_CYC = 6;
  localparam int LO = (OP_TICKS - 2) * OSC_CYC;
  localparam int HI = (OP_TICKS + 2) * OSC_CYC;
  logic [15:0] cnt_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_por_rst);
  // Cycles of the current stall
  always_ff @(posedge i_clk) begin
    if (i_por_rst || o_prog_start)
      cnt_reg <= 16'h0000;
    else if (o_cpu_stall)
      cnt_reg <= cnt_reg + 16'h0001;
  end
  a_ctrl_reserved: assert property (
    (i_read && !o_waitrequest && i_address == `FSPS_OFS_CTRL)
    |-> o_readdata[31:6] == 26'h0) else $error("ctrl top bits set");
  a_start_single: assert property (
    o_prog_start |=> (!o_prog_start && o_cpu_stall))
    else $error("start pulse or stall wrong");
  a_start_allowed: assert property (
    o_prog_start |-> (!$past(i_self_program_fuse)
      && !$past(i_eeprom_write_busy)))
    else $error("start while blocked");
  a_page_held: assert property (
    (o_cpu_stall && !o_prog_start) |-> $stable(o_prog_page))
    else $error("page moved during operation");
  a_stall_blocks: assert property (
    o_cpu_stall |-> o_waitrequest) else $error("bus served during stall");
  a_op_length: assert property (
    $fell(o_cpu_stall) |-> (cnt_reg >= LO && cnt_reg <= HI))
    else $error("operation length out of range");
  a_buf_reset: assert property (
    (i_rst && !o_cpu_stall) |-> ##2 (o_buf_word == 16'hFFFF))
    else $error("buffer kept data over reset");
  a_op_survives: assert property (
    (o_cpu_stall && i_rst && cnt_reg < 16'(LO - 8)) |=> o_cpu_stall [*3])
    else $error("reset cut an operation");
  // Main scenarios
  c_erase: cover property (o_prog_start && o_prog_erase);
  c_write: cover property (o_prog_start && !o_prog_erase);
  c_rst_op: cover property (o_cpu_stall && i_rst);
endmodule : fsps_sequencer_sva

bind fsps_sequencer fsps_sequencer_sva #(
  .PAGE_BITS(PAGE_BITS), .OP_TICKS(OP_TICKS)
) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_por_rst(i_por_rst),
  .i_address(i_address), .i_read(i_read), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .i_eeprom_write_busy(i_eeprom_write_busy),
  .i_self_program_fuse(i_self_program_fuse), .o_prog_start(o_prog_start),
  .o_prog_erase(o_prog_erase), .o_prog_page(o_prog_page),
  .o_buf_word(o_buf_word), .o_cpu_stall(o_cpu_stall)
);

// ---- sim/fsps_sequencer_tb.sv ----
// Purpose: Self-checking bench of the flash self-program sequencer
// Assumes: Short operation count, partner gives flash and oscillator
// Notes: Notes of expected results are queued, a monitor compares
`timescale 1ns/10ps
`include "fsps_defines.svh"
module fsps_sequencer_tb;
  logic i_clk, i_rst, i_por_rst, i_read, i_write, o_waitrequest;
  logic i_eeprom_write_busy, i_self_program_fuse, i_osc_8m, o_cpu_stall;
  logic o_prog_start, o_prog_erase;
  logic [3:0] i_byteenable, i_flash_buf_idx, w;
  logic [4:0] i_address;
  logic [6:0] o_prog_page, p;
  logic [7:0] i_fuse_byte, i_lock_byte;
  logic [14:0] o_flash_raddr;
  logic [15:0] o_buf_word, i_flash_rdata, z, d;
  logic [31:0] i_writedata, o_readdata;
  logic [31:0] exp_rd[$];
  logic [7:0] exp_pg[$];
  logic [5:0] cmd_tab[5] = '{6'h21, 6'h09, 6'h05, 6'h03, 6'h01};
  logic [5:0] bad_tab[4] = '{6'h07, 6'h3F, 6'h02, 6'h20};
  logic [7:0] sig_tab[4] = '{`FSPS_SIG0, `FSPS_SIG1, `FSPS_SIG2, `FSPS_SIG3};
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed, i;
  fsps_sequencer #(.OP_TICKS(8)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_por_rst(i_por_rst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(i_byteenable), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_eeprom_write_busy(i_eeprom_write_busy),
    .i_self_program_fuse(i_self_program_fuse), .i_fuse_byte(i_fuse_byte),
    .i_lock_byte(i_lock_byte), .i_osc_8m(i_osc_8m),
    .o_prog_start(o_prog_start), .o_prog_erase(o_prog_erase),
    .o_prog_page(o_prog_page), .i_flash_buf_idx(i_flash_buf_idx),
    .o_buf_word(o_buf_word), .o_flash_raddr(o_flash_raddr),
    .i_flash_rdata(i_flash_rdata), .o_cpu_stall(o_cpu_stall)
  );
  fsps_flash_model u_flash (
    .i_clk(i_clk), .i_raddr(o_flash_raddr), .o_rdata(i_flash_rdata),
    .o_osc(i_osc_8m)
  );
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Compare helpers
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_rd
  task automatic cmp_pg(input logic [7:0] g, input logic [7:0] e);
    cmp_rd({24'h0, g}, {24'h0, e});
  endtask : cmp_pg
  // Verdict and end of run
  task automatic results;
    $display("Mismatches %0d, compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= v;
    i_write <= wr;
    i_read <= ~wr;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Pointer, data pair, command, then store
  task automatic prog(input logic [15:0] zz, dd, input logic [5:0] c);
    bus(1'b1, `FSPS_OFS_POINTER, {16'h0, zz});
    bus(1'b1, `FSPS_OFS_DATA, {16'h0, dd});
    bus(1'b1, `FSPS_OFS_CTRL, {26'h0, c});
    bus(1'b1, `FSPS_OFS_STORE, 32'h0);
  endtask : prog
  // Pointer, optional command, load, then result read
  task automatic lp(input logic [15:0] zz, input logic [5:0] c,
                    input logic [7:0] e);
    bus(1'b1, `FSPS_OFS_POINTER, {16'h0, zz});
    if (c != 6'h00)
      bus(1'b1, `FSPS_OFS_CTRL, {26'h0, c});
    bus(1'b1, `FSPS_OFS_LOAD, 32'h0);
    rd(`FSPS_OFS_RESULT, {24'h0, e});
  endtask : lp
  // Buffer word as the flash array sees it
  task automatic bufchk(input logic [3:0] wi, input logic [15:0] e);
    @(posedge i_clk);
    i_flash_buf_idx <= wi;
    repeat (2) @(posedge i_clk);
    cmp_rd({16'h0, o_buf_word}, {16'h0, e});
  endtask : bufchk
  task automatic rstp;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : rstp
  // Monitor of results and cycle ceiling
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
    if (i_read === 1'b1 && o_waitrequest === 1'b0)
      cmp_rd(o_readdata, exp_rd.pop_front());
    if (o_prog_start === 1'b1)
      cmp_pg({o_prog_erase, o_prog_page}, exp_pg.pop_front());
  end
  // Main sequence
  initial begin
    seed = 32'h6c2d;
    i_rst = 1'b1;
    i_por_rst = 1'b1;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 5'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    i_eeprom_write_busy = 1'b0;
    i_self_program_fuse = 1'b0;
    i_fuse_byte = 8'($random(seed));
    i_lock_byte = 8'($random(seed));
    i_flash_buf_idx = 4'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    i_por_rst <= 1'b0;
    rd(`FSPS_OFS_CTRL, 32'h0);
    bus(1'b1, 5'h1C, 32'($random(seed)));
    rd(5'h1C, 32'h0);
    rd(`FSPS_OFS_STATUS, 32'h4);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `FSPS_OFS_CTRL, {24'h0, 2'b11, bad_tab[i]});
      rd(`FSPS_OFS_CTRL, 32'h0);
    end
    for (i = 0; i < 5; i++) begin
      bus(1'b1, `FSPS_OFS_CTRL, {24'h0, 2'b11, cmd_tab[i]});
      rd(`FSPS_OFS_CTRL, {26'h0, cmd_tab[i]});
      repeat (5) @(posedge i_clk);
      rd(`FSPS_OFS_CTRL, 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      z = 16'($random(seed));
      z[0] = i[0];
      lp(z, 6'h00, z[0] ? z[8:1] ^ 8'h3C : z[15:8]);
      lp({13'h0, i[1:0], 1'b0}, `FSPS_CMD_SIG, sig_tab[i]);
      lp({15'h0, i[0]}, `FSPS_CMD_FUSE, i[0] ? i_fuse_byte : i_lock_byte);
    end
    p = 7'($random(seed));
    w = 4'($random(seed));
    d = 16'($random(seed));
    prog({4'hA, p, w, 1'b1}, d, `FSPS_CMD_LOAD);
    bufchk(w, d);
    prog({4'h0, p, w + 4'h1, 1'b0}, ~d, `FSPS_CMD_LOAD);
    bus(1'b1, `FSPS_OFS_CTRL, {26'h0, `FSPS_CMD_CLR});
    bufchk(w + 4'h1, `FSPS_BUF_ERASED);
    bufchk(w, `FSPS_BUF_ERASED);
    prog({4'h0, p, w, 1'b0}, d, `FSPS_CMD_LOAD);
    i_eeprom_write_busy <= 1'b1;
    bufchk(w, `FSPS_BUF_ERASED);
    bus(1'b1, `FSPS_OFS_CTRL, {26'h0, `FSPS_CMD_LOAD});
    rd(`FSPS_OFS_CTRL, 32'h0);
    i_eeprom_write_busy <= 1'b0;
    prog({4'h0, p, w, 1'b0}, d, `FSPS_CMD_LOAD);
    exp_pg.push_back({1'b1, p});
    prog({4'hF, p, 4'h9, 1'b1}, ~d, `FSPS_CMD_ERASE);
    rstp();
    rd(`FSPS_OFS_CTRL, 32'h0);
    bufchk(w, d);
    exp_pg.push_back({1'b0, p});
    prog({4'h0, p, 4'h0, 1'b0}, ~d, `FSPS_CMD_WRITE);
    rd(`FSPS_OFS_CTRL, 32'h0);
    bufchk(w, `FSPS_BUF_ERASED);
    i_self_program_fuse <= 1'b1;
    prog({4'h0, p, 4'h0, 1'b0}, d, `FSPS_CMD_ERASE);
    i_self_program_fuse <= 1'b0;
    bus(1'b1, `FSPS_OFS_CTRL, {26'h0, `FSPS_CMD_ERASE});
    repeat (5) @(posedge i_clk);
    bus(1'b1, `FSPS_OFS_STORE, 32'h0);
    prog({4'h0, p, w, 1'b0}, d, `FSPS_CMD_LOAD);
    rstp();
    bufchk(w, `FSPS_BUF_ERASED);
    repeat (20) @(posedge i_clk);
    results();
  end
endmodule : fsps_sequencer_tb
